/* File: hdl/itec_pkg.sv */
// constants and carrier types for the interval timer / event counter
// assumes a single master clock domain; all core controls synchronous to it
`default_nettype none
package itec_pkg;
  // ---------------------------------------------------------------
  // clock division, count and interrupt vector constants
  // ---------------------------------------------------------------
  localparam int unsigned STATE_DIV = 3;
  localparam int unsigned CYCLE_DIV = 5;
  localparam int unsigned PRESCALE_DIV = 32;
  localparam int unsigned COUNT_W = 8;
  localparam logic [7:0] TIMER_VECTOR = 8'h07;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [4:0] PRESCALE_LAST = 5'h1F;
  localparam logic [1:0] STATE_LAST = 2'h2;
  localparam logic [2:0] CYCLE_LAST = 3'h4;

  typedef enum logic [1:0] {MODE_STOPPED, MODE_TIMER, MODE_COUNTER} mode_e;

  // one instruction-driven control request, one cycle wide
  typedef struct packed {
    logic load;
    logic [7:0] load_value;
    logic start_timer;
    logic start_counter;
    logic stop;
  } ctrl_s;
endpackage
`default_nettype wire

/* File: hdl/clock_divider.sv */
// divides the master clock into state and cycle strobes
// assumes synchronous active-low reset on the master clock
`default_nettype none
module clock_divider
  import itec_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic state_tick_o,
  output logic cycle_tick_o
);
  logic [1:0] state_cnt_q;
  logic [2:0] cycle_cnt_q;
  wire state_wrap = (state_cnt_q == STATE_LAST);
  wire cycle_wrap = state_wrap && (cycle_cnt_q == CYCLE_LAST);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_cnt_q <= 2'h0;
      cycle_cnt_q <= 3'h0;
      state_tick_o <= 1'b0;
      cycle_tick_o <= 1'b0;
    end else begin
      state_cnt_q <= state_wrap ? 2'h0 : state_cnt_q + 2'h1;
      if (state_wrap) begin
        cycle_cnt_q <= (cycle_cnt_q == CYCLE_LAST) ? 3'h0 : cycle_cnt_q + 3'h1;
      end
      state_tick_o <= state_wrap;
      cycle_tick_o <= cycle_wrap;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/interval_timer_event_counter.sv */
// 8-bit interval timer / event counter with its clock dividers
// assumes the core issues one-cycle control strobes on CLK_I
`default_nettype none
module interval_timer_event_counter
  import itec_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire itec_pkg::ctrl_s CTRL_I,
  input wire logic EVENT_SENSE_INPUT_I,
  input wire logic IRQ_ACK_I,
  output logic [7:0] COUNT_O,
  output itec_pkg::mode_e MODE_O,
  output logic IRQ_O,
  output logic [7:0] IRQ_VECTOR_O,
  output logic CYCLE_TICK_O
);
  import itec_pkg::*;

  // ---------------------------------------------------------------
  // clocks
  // ---------------------------------------------------------------
  logic state_tick;
  logic cycle_tick;

  clock_divider u_div (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .state_tick_o(state_tick),
    .cycle_tick_o(cycle_tick)
  );

  // ---------------------------------------------------------------
  // mode and tick sources
  // ---------------------------------------------------------------
  mode_e mode_q;
  mode_e mode_d;
  logic [4:0] pre_q;
  logic sense_now_q;
  logic [7:0] count_q;
  logic irq_q;

  // stop wins over a simultaneous start; load never touches the mode
  always_comb begin
    mode_d = mode_q;
    if (CTRL_I.stop) begin
      mode_d = MODE_STOPPED;
    end else if (CTRL_I.start_timer) begin
      mode_d = MODE_TIMER;
    end else if (CTRL_I.start_counter) begin
      mode_d = MODE_COUNTER;
    end
  end

  wire pre_wrap = cycle_tick && (pre_q == PRESCALE_LAST);
  wire fall_seen = cycle_tick && sense_now_q && !EVENT_SENSE_INPUT_I;
  wire timer_inc = (mode_q == MODE_TIMER) && pre_wrap;
  wire counter_inc = (mode_q == MODE_COUNTER) && fall_seen;
  wire do_inc = (timer_inc || counter_inc) && !CTRL_I.load;
  wire rollover = do_inc && (count_q == COUNT_MAX);

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode_q <= MODE_STOPPED;
      pre_q <= 5'h00;
      sense_now_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      if (cycle_tick) begin
        pre_q <= pre_q + 5'h01;
        sense_now_q <= EVENT_SENSE_INPUT_I;
      end
    end
  end

  // ---------------------------------------------------------------
  // count register: deliberately outside the reset branch
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (CTRL_I.load) begin
      count_q <= CTRL_I.load_value;
    end else if (do_inc) begin
      count_q <= count_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // interrupt request: set wins over acknowledge
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      irq_q <= 1'b0;
    end else if (rollover) begin
      irq_q <= 1'b1;
    end else if (IRQ_ACK_I) begin
      irq_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      COUNT_O <= COUNT_ZERO;
      MODE_O <= MODE_STOPPED;
      IRQ_O <= 1'b0;
      IRQ_VECTOR_O <= TIMER_VECTOR;
      CYCLE_TICK_O <= 1'b0;
    end else begin
      COUNT_O <= count_q;
      MODE_O <= mode_q;
      IRQ_O <= irq_q;
      IRQ_VECTOR_O <= TIMER_VECTOR;
      CYCLE_TICK_O <= cycle_tick;
    end
  end

  // ---------------------------------------------------------------
  // check helpers: spacing of timer steps
  // ---------------------------------------------------------------
  // the first step after a start may come early, as the prescaler runs free
  localparam logic [9:0] TIMER_GAP_LAST = 10'(PRESCALE_DIV * STATE_DIV * CYCLE_DIV - 1);
  logic [9:0] gap_q;
  logic seen_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || (mode_q != MODE_TIMER)) begin
      gap_q <= 10'h000;
      seen_q <= 1'b0;
    end else if (timer_inc) begin
      gap_q <= 10'h000;
      seen_q <= 1'b1;
    end else if (gap_q != 10'h3FF) begin
      gap_q <= gap_q + 10'h001;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_ROLL_IRQ: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    rollover |=> irq_q && (count_q == COUNT_ZERO))
    else $error("rollover did not raise request at zero");
  AST_STOP_FREEZE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (mode_q == MODE_STOPPED) && !CTRL_I.load |=> $stable(count_q))
    else $error("stopped count moved");
  AST_LOAD_KEEPS_MODE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CTRL_I.load && !CTRL_I.stop && !CTRL_I.start_timer && !CTRL_I.start_counter
    |=> $stable(mode_q) && (count_q == $past(CTRL_I.load_value)))
    else $error("load disturbed mode or value");
  AST_TIMER_RATE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    timer_inc && seen_q |-> gap_q == TIMER_GAP_LAST)
    else $error("timer step spacing wrong");
  AST_CYCLE_PERIOD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    cycle_tick |=> !cycle_tick [*8] ##1 !cycle_tick [*6] ##1 cycle_tick)
    else $error("cycle clock period not fifteen");
  AST_STATE_PERIOD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    state_tick |=> !state_tick [*2] ##1 state_tick)
    else $error("state clock period not three");
  AST_EDGE_ONLY_FALL: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (mode_q == MODE_COUNTER) && !CTRL_I.load
    && !(cycle_tick && sense_now_q && !EVENT_SENSE_INPUT_I) |=> $stable(count_q))
    else $error("count without falling edge");
  AST_MODE_SOURCE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (mode_q == MODE_TIMER) && !CTRL_I.load && !pre_wrap |=> $stable(count_q))
    else $error("count from wrong source");
  AST_INC_ONE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    do_inc |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not advance by one");

  // ---------------------------------------------------------------
  // checks: mode, prescaler and sense sampling
  // ---------------------------------------------------------------
  AST_START_TIMER: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CTRL_I.start_timer && !CTRL_I.stop |=> mode_q == MODE_TIMER)
    else $error("timer start not taken");
  AST_START_COUNTER: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CTRL_I.start_counter && !CTRL_I.start_timer && !CTRL_I.stop |=> mode_q == MODE_COUNTER)
    else $error("counter start not taken");
  AST_STOP_MODE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CTRL_I.stop |=> mode_q == MODE_STOPPED)
    else $error("stop not taken");
  AST_PRE_STEP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    cycle_tick |=> pre_q == $past(pre_q) + 5'h01)
    else $error("prescaler missed a cycle tick");
  AST_PRE_HOLD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !cycle_tick |=> $stable(pre_q))
    else $error("prescaler moved between cycle ticks");
  AST_SENSE_HOLD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !cycle_tick |=> $stable(sense_now_q))
    else $error("sense sampled between cycle ticks");

  // ---------------------------------------------------------------
  // checks: interrupt request and registered outputs
  // ---------------------------------------------------------------
  AST_ACK_CLEARS: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    IRQ_ACK_I && !rollover |=> !irq_q)
    else $error("acknowledge did not clear request");
  AST_IRQ_HOLD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    irq_q && !IRQ_ACK_I |=> irq_q)
    else $error("request dropped without acknowledge");
  AST_COUNT_SHOWN: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    1'b1 |=> COUNT_O == $past(count_q))
    else $error("count output does not follow count");
  AST_MODE_SHOWN: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    1'b1 |=> MODE_O == $past(mode_q))
    else $error("mode output does not follow mode");
  AST_IRQ_SHOWN: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    1'b1 |=> IRQ_O == $past(irq_q))
    else $error("request output does not follow request");
endmodule
`default_nettype wire

/* File: verification/event_source.sv */
// partner: external event source that drives the sense pin
// assumes clk_i is the bench clock; the pin idles high as if pulled up
`default_nettype none
module event_source (
  input wire logic clk_i,
  output logic sense_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial sense_o = 1'b1;
  // each phase spans two cycle ticks, so one sample always lands in it
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (30) @(negedge clk_i);
      sense_o = 1'b0;
      repeat (30) @(negedge clk_i);
      sense_o = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/interval_timer_event_counter_tb_top.sv */
// self-checking bench for the interval timer / event counter
// assumes the package itec_pkg and the event_source partner are compiled first
`default_nettype none
module interval_timer_event_counter_tb_top import itec_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ack = 1'b0;
  ctrl_s ctrl = '0;
  wire logic sense;
  logic [7:0] count;
  logic [7:0] vec;
  mode_e mode;
  logic irq;
  logic tick;
  int err_count = 0;
  int n_compared = 0;
  always #25 clk = ~clk;
  event_source i_src (.clk_i(clk), .sense_o(sense));
  interval_timer_event_counter i_dut (.CLK_I(clk), .RST_N_I(rst_n), .CTRL_I(ctrl),
    .EVENT_SENSE_INPUT_I(sense), .IRQ_ACK_I(ack), .COUNT_O(count), .MODE_O(mode),
    .IRQ_O(irq), .IRQ_VECTOR_O(vec), .CYCLE_TICK_O(tick));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input ctrl_s c);
    @(negedge clk);
    ctrl = c;
    @(negedge clk);
    ctrl = '0;
    @(negedge clk);
  endtask
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic results();
    $display("mismatches %0d, comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_keeps();
    int n;
    cmd('{load: 1'b1, load_value: 8'h5A, default: 1'b0});
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(count, 8'h5A);
    chk(8'(mode), 8'(MODE_STOPPED));
    chk(vec, 8'h07);
    n = 0;
    @(posedge tick);
    @(negedge clk);
    // the tick is still up at this edge, so step once before looking again
    do begin
      n++;
      @(negedge clk);
    end while (tick !== 1'b1 && n < 40);
    chk(n, STATE_DIV * CYCLE_DIV);
  endtask
  task automatic t_timer();
    int n;
    cmd('{load: 1'b1, load_value: 8'hFD, default: 1'b0});
    cmd('{start_timer: 1'b1, default: 1'b0});
    chk(8'(mode), 8'(MODE_TIMER));
    // the prescaler runs free, so the first step lands anywhere in one period
    for (int i = 0; i < 600 && count !== 8'hFE; i++) @(negedge clk);
    chk(count, 8'hFE);
    n = 0;
    while (count !== 8'hFF && n < 600) begin
      n++;
      @(negedge clk);
    end
    chk(n, PRESCALE_DIV * STATE_DIV * CYCLE_DIV);
    wait_irq(600);
    chk(8'(irq), 8'h01);
    chk(count, 8'h00);
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    repeat (2) @(negedge clk);
    chk(8'(irq), 8'h00);
    repeat (500) @(negedge clk);
    chk(count, 8'h01);
  endtask
  task automatic t_counter();
    cmd('{load: 1'b1, load_value: 8'hFD, default: 1'b0});
    cmd('{start_counter: 1'b1, default: 1'b0});
    cmd('{load: 1'b1, load_value: 8'hFD, default: 1'b0});
    chk(8'(mode), 8'(MODE_COUNTER));
    i_src.pulse(2);
    chk(count, 8'hFF);
    i_src.pulse(1);
    wait_irq(20);
    chk(8'(irq), 8'h01);
    chk(count, 8'h00);
    i_src.pulse(1);
    chk(count, 8'h01);
    cmd('{stop: 1'b1, default: 1'b0});
    i_src.pulse(2);
    chk(count, 8'h01);
    chk(8'(mode), 8'(MODE_STOPPED));
  endtask
  initial begin
    // the count is never reset, so give it a known value while reset is held
    cmd('{load: 1'b1, load_value: 8'h00, default: 1'b0});
    repeat (7) @(negedge clk);
    rst_n = 1'b1;
    t_reset_keeps();
    t_timer();
    t_counter();
    results();
  end
  initial begin
    #1000000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
